// File: hw/rdc_cfg.svh
// Constants for the resync tail selector.
`ifndef RDC_CFG_SVH
`define RDC_CFG_SVH

`define RDC_PREFIX_LEN   5'h14
`define RDC_PREFIX_PAT   20'h10102
`define RDC_PREFIX_MASK  20'hBFFFF
`define RDC_TAIL_LEN     5'h04
`define RDC_TAIL_FIRST   3'h0
`define RDC_TAIL_SECOND  3'h4
`define RDC_LAST_STEP    6'h27
`define RDC_SUM_W        16

`endif

// File: hw/rdc_dsv_track.sv
// Running digital sum of one candidate path over position-modulated bits.
`include "rdc_cfg.svh"
module rdc_dsv_track #(
    parameter int SUM_W = `RDC_SUM_W
) (
    // Clock and reset.
    input  wire logic                    ref_clk,
    input  wire logic                    rst,
    // Bit stream.
    input  wire logic                    bit_en,
    input  wire logic                    ppm_bit,
    // State reload from the chosen path.
    input  wire logic                    load,
    input  wire logic signed [SUM_W-1:0] load_sum,
    input  wire logic                    load_level,
    // Current state.
    output logic signed [SUM_W-1:0]      sum,
    output logic                         level
);
    logic signed [SUM_W-1:0] sum_q;
    logic signed [SUM_W-1:0] sum_d;
    logic                    level_q;
    wire logic               pwm_bit;
    wire logic signed [SUM_W-1:0] step;

    // A ONE toggles the written level; each bit then weighs by that level.
    assign pwm_bit = level_q ^ ppm_bit;
    assign step    = pwm_bit ? SUM_W'(1) : -SUM_W'(1);
    assign sum_d   = sum_q + step;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sum_q   <= '0;
            level_q <= 1'b0;
        end else if (load) begin
            sum_q   <= load_sum;
            level_q <= load_level;
        end else if (bit_en) begin
            sum_q   <= sum_d;
            level_q <= pwm_bit;
        end
    end

    assign sum   = sum_q;
    assign level = level_q;
endmodule

// File: hw/rdc_pkg.sv
// Types shared by the resync tail selector.
package rdc_pkg;
    typedef enum logic [2:0] {
        RDC_KIND_PREAMBLE,
        RDC_KIND_SYNC,
        RDC_KIND_DATA,
        RDC_KIND_PREFIX,
        RDC_KIND_TAIL
    } rdc_kind_t;
endpackage

// File: hw/rdc_selector.sv
// Resync tail selector that keeps the d.c. level of a sector's data field low.
`include "rdc_cfg.svh"
module rdc_selector #(
    parameter int SUM_W = `RDC_SUM_W
) (
    // Clock and sector-start reset.
    input  wire logic                    ref_clk,
    input  wire logic                    rst,
    // Channel bits from the modulation encoder.
    input  wire logic                    in_valid,
    output logic                         in_ready,
    input  wire logic                    in_bit,
    input  wire rdc_pkg::rdc_kind_t      in_kind,
    input  wire logic                    in_last,
    // Decisions to the write channel.
    output logic                         sel_valid,
    output logic                         sel_second,
    output logic [5:0]                   sel_step,
    output logic signed [SUM_W-1:0]      run_sum,
    // Status.
    output logic                         done,
    output logic                         order_err
);
    typedef enum logic [2:0] {
        ST_PRE, ST_SYNC, ST_DATA, ST_PREFIX, ST_TAIL, ST_PEND, ST_DONE
    } rdc_state_t;

    // Literals cannot be bit-selected, so the fixed patterns are held as constants here.
    localparam logic [`RDC_PREFIX_LEN-1:0] PREFIX_PAT  = `RDC_PREFIX_PAT;
    localparam logic [`RDC_PREFIX_LEN-1:0] PREFIX_MASK = `RDC_PREFIX_MASK;
    localparam logic [2:0]                 TAIL_FIRST  = `RDC_TAIL_FIRST;
    localparam logic [2:0]                 TAIL_SECOND = `RDC_TAIL_SECOND;

    rdc_state_t              state_q;
    rdc_state_t              state_d;
    logic [4:0]              cnt_q;
    logic [4:0]              cnt_d;
    logic [5:0]              blk_q;
    logic                    final_q;
    logic                    sel_valid_q;
    logic                    sel_second_q;
    logic [5:0]              sel_step_q;
    logic signed [SUM_W-1:0] run_sum_q;
    logic                    order_err_q;

    wire logic                    take;
    wire logic                    kind_ok;
    wire logic                    last_ok;
    wire logic                    is_k_pre;
    wire logic                    is_k_sync;
    wire logic                    is_k_data;
    wire logic                    is_k_prefix;
    wire logic                    is_k_tail;
    wire logic                    end_block;
    wire logic                    prefix_end;
    wire logic                    tail_end;
    wire logic                    prefix_bad;
    wire logic [4:0]              pfx_idx;
    wire logic [4:0]              pfx_pos;
    wire logic [1:0]              tail_pos;
    wire logic                    tail_fixed;
    wire logic                    bit_a;
    wire logic                    bit_b;
    wire logic                    pick_b;
    wire logic                    bit_en;
    wire logic                    load;
    wire logic signed [SUM_W-1:0] sum_a;
    wire logic signed [SUM_W-1:0] sum_b;
    wire logic signed [SUM_W-1:0] abs_a;
    wire logic signed [SUM_W-1:0] abs_b;
    wire logic signed [SUM_W-1:0] pick_sum;
    wire logic                    level_a;
    wire logic                    level_b;
    wire logic                    pick_level;

    assign is_k_pre    = in_kind == rdc_pkg::RDC_KIND_PREAMBLE;
    assign is_k_sync   = in_kind == rdc_pkg::RDC_KIND_SYNC;
    assign is_k_data   = in_kind == rdc_pkg::RDC_KIND_DATA;
    assign is_k_prefix = in_kind == rdc_pkg::RDC_KIND_PREFIX;
    assign is_k_tail   = in_kind == rdc_pkg::RDC_KIND_TAIL;

    // Only the final data block may carry the end-of-field mark.
    assign last_ok = !in_last || (state_q == ST_DATA && is_k_data && blk_q == `RDC_LAST_STEP);
    assign kind_ok = last_ok && (
        (state_q == ST_PRE    && (is_k_pre || is_k_sync)) ||
        (state_q == ST_SYNC   && (is_k_sync || is_k_data)) ||
        (state_q == ST_DATA   && (is_k_data || (is_k_prefix && blk_q != `RDC_LAST_STEP))) ||
        (state_q == ST_PREFIX && is_k_prefix) ||
        (state_q == ST_TAIL   && is_k_tail));

    assign in_ready   = state_q != ST_PEND && state_q != ST_DONE;
    assign take       = in_valid && in_ready;
    assign bit_en     = take && kind_ok;
    assign end_block  = bit_en && is_k_data && in_last;
    assign prefix_end = bit_en && is_k_prefix && state_q == ST_PREFIX
                        && cnt_q == `RDC_PREFIX_LEN - 5'h01;
    assign tail_end   = bit_en && state_q == ST_TAIL && cnt_q == `RDC_TAIL_LEN - 5'h01;

    // The first prefix bit is taken while the block is still open, so it sits at index 0 (pattern bit 19).
    assign pfx_idx    = (state_q == ST_PREFIX) ? cnt_q : 5'h00;
    assign pfx_pos    = `RDC_PREFIX_LEN - 5'h01 - pfx_idx;
    // Prefix bits are fixed except the x position, which the encoder sets.
    assign prefix_bad = bit_en && is_k_prefix
                        && (state_q == ST_DATA || state_q == ST_PREFIX)
                        && PREFIX_MASK[pfx_pos]
                        && in_bit != PREFIX_PAT[pfx_pos];

    // The first three tail bits belong to the variant; y comes from the encoder.
    assign tail_pos   = 2'(5'h02 - cnt_q);
    assign tail_fixed = state_q == ST_TAIL && cnt_q < `RDC_TAIL_LEN - 5'h01;
    assign bit_a = tail_fixed ? TAIL_FIRST[tail_pos]  : in_bit;
    assign bit_b = tail_fixed ? TAIL_SECOND[tail_pos] : in_bit;

    assign abs_a      = sum_a < 0 ? -sum_a : sum_a;
    assign abs_b      = sum_b < 0 ? -sum_b : sum_b;
    assign pick_b     = abs_b < abs_a;
    assign pick_sum   = pick_b ? sum_b : sum_a;
    assign pick_level = pick_b ? level_b : level_a;
    assign load       = state_q == ST_PEND;

    rdc_dsv_track #(.SUM_W(SUM_W)) u_path_a (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .bit_en     (bit_en),
        .ppm_bit    (bit_a),
        .load       (load),
        .load_sum   (pick_sum),
        .load_level (pick_level),
        .sum        (sum_a),
        .level      (level_a)
    );

    rdc_dsv_track #(.SUM_W(SUM_W)) u_path_b (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .bit_en     (bit_en),
        .ppm_bit    (bit_b),
        .load       (load),
        .load_sum   (pick_sum),
        .load_level (pick_level),
        .sum        (sum_b),
        .level      (level_b)
    );

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        unique case (state_q)
            ST_PRE: begin
                if (bit_en && is_k_sync) state_d = ST_SYNC;
            end
            ST_SYNC: begin
                if (bit_en && is_k_data) state_d = ST_DATA;
            end
            ST_DATA: begin
                if (end_block) begin
                    state_d = ST_PEND;
                end else if (bit_en && is_k_prefix) begin
                    state_d = ST_PREFIX;
                    cnt_d   = 5'h01;
                end
            end
            ST_PREFIX: begin
                if (prefix_end) begin
                    // The first prefix closes the opening sum; later ones close a step.
                    state_d = (blk_q == 6'h00) ? ST_TAIL : ST_PEND;
                    cnt_d   = '0;
                end else if (bit_en) begin
                    cnt_d = cnt_q + 5'h01;
                end
            end
            ST_TAIL: begin
                if (tail_end) begin
                    state_d = ST_DATA;
                    cnt_d   = '0;
                end else if (bit_en) begin
                    cnt_d = cnt_q + 5'h01;
                end
            end
            ST_PEND: state_d = final_q ? ST_DONE : ST_TAIL;
            ST_DONE: state_d = ST_DONE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= ST_PRE;
            cnt_q   <= '0;
            blk_q   <= '0;
            final_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            if (tail_end) blk_q <= blk_q + 6'h01;
            if (end_block) final_q <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sel_valid_q  <= 1'b0;
            sel_second_q <= 1'b0;
            sel_step_q   <= '0;
            run_sum_q    <= '0;
            order_err_q  <= 1'b0;
        end else begin
            sel_valid_q <= load;
            if (load) begin
                sel_second_q <= pick_b;
                sel_step_q   <= blk_q;
                run_sum_q    <= pick_sum;
            end
            if ((take && !kind_ok) || prefix_bad) order_err_q <= 1'b1;
        end
    end

    assign sel_valid  = sel_valid_q;
    assign sel_second = sel_second_q;
    assign sel_step   = sel_step_q;
    assign run_sum    = run_sum_q;
    assign done       = state_q == ST_DONE;
    assign order_err  = order_err_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_pend_stall: assert property (state_q == ST_PEND |-> !in_ready)
        else $error("input accepted while a step is being decided");
    a_tie_first: assert property (state_q == ST_PEND && abs_a == abs_b |=> sel_valid_q && !sel_second_q)
        else $error("tie did not pick the first tail");
    a_pick_smaller: assert property (state_q == ST_PEND && abs_b < abs_a |=> sel_second_q)
        else $error("smaller second path not chosen");
    a_carry_state: assert property (state_q == ST_PEND |=> sum_a == sum_b && level_a == level_b
                                    && run_sum_q == sum_a)
        else $error("paths not restarted from the chosen state");
    a_final_step: assert property (sel_valid_q && sel_step_q == `RDC_LAST_STEP |-> state_q == ST_DONE)
        else $error("last step did not end the field");
    a_step_range: assert property (sel_valid_q |-> sel_step_q >= 6'h01 && sel_step_q <= `RDC_LAST_STEP)
        else $error("decision outside steps 1 to 39");
    a_pwm_toggle: assert property (bit_en && bit_a |=> level_a != $past(level_a))
        else $error("a ONE did not toggle the written level");
    a_order_flag: assert property (take && !kind_ok |=> order_err_q)
        else $error("out-of-order segment not flagged");
    a_prefix_flag: assert property (prefix_bad |=> order_err_q)
        else $error("bad prefix bit not flagged");

    c_pick_first:  cover property (sel_valid_q && !sel_second_q);
    c_pick_second: cover property (sel_valid_q && sel_second_q);
    c_field_done:  cover property (state_q == ST_PEND ##1 state_q == ST_DONE);
endmodule

// File: sim/rdc_enc_model.sv
// Upstream encoder model that offers queued channel bits and honours the stall.
module rdc_enc_model (
    // Clock and reset.
    input  wire logic          ref_clk,
    input  wire logic          rst,
    // Handshake from the selector and pacing from the bench.
    input  wire logic          in_ready,
    input  wire logic          slow,
    // Bit lanes toward the selector.
    output logic               in_valid,
    output logic               in_bit,
    output rdc_pkg::rdc_kind_t in_kind,
    output logic               in_last
);
    timeunit 1ns;
    timeprecision 1ps;
    logic               qb[$];
    rdc_pkg::rdc_kind_t qk[$];
    logic               ql[$];
    logic               taken;
    initial begin
        in_valid = 1'h0;
        in_bit = 1'h0;
        in_kind = rdc_pkg::RDC_KIND_PREAMBLE;
        in_last = 1'h0;
        taken = 1'h0;
    end
    task automatic push(input logic b, input rdc_pkg::rdc_kind_t k, input logic l);
        qb.push_back(b);
        qk.push_back(k);
        ql.push_back(l);
    endtask
    always @(posedge ref_clk) taken <= in_valid && in_ready && !rst;
    // An offered bit stays put until a rising edge takes it; while idle, in_bit keeps toggling.
    always @(negedge ref_clk) begin
        if (rst) begin
            qb.delete();
            qk.delete();
            ql.delete();
            in_valid <= 1'h0;
        end else if (!in_valid || taken) begin
            if (taken) begin
                void'(qb.pop_front());
                void'(qk.pop_front());
                void'(ql.pop_front());
            end
            if (qb.size() > 0 && (!slow || $urandom_range(2, 0) == 0)) begin
                in_valid <= 1'h1;
                in_bit <= qb[0];
                in_kind <= qk[0];
                in_last <= ql[0];
            end else begin
                in_valid <= 1'h0;
                in_bit <= ~in_bit;
                in_last <= 1'h0;
            end
        end
    end
endmodule

// File: sim/rdc_selector_test.sv
// Self-checking bench for the resync tail selector.
module rdc_selector_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SUM_W = 16;
    logic                    ref_clk, rst, slow, in_valid, in_ready, in_bit, in_last;
    rdc_pkg::rdc_kind_t      in_kind;
    logic                    sel_valid, sel_second, done, order_err, l_a, l_b;
    logic [5:0]              sel_step;
    logic signed [SUM_W-1:0] run_sum;
    int                      fails, num_checks, s_a, s_b;
    int                      exp_sum[$], exp_step[$];
    logic                    exp_sec[$];

    rdc_enc_model i_enc (.ref_clk(ref_clk), .rst(rst), .in_ready(in_ready), .slow(slow),
        .in_valid(in_valid), .in_bit(in_bit), .in_kind(in_kind), .in_last(in_last));
    rdc_selector #(.SUM_W(SUM_W)) i_dut (.ref_clk(ref_clk), .rst(rst), .in_valid(in_valid),
        .in_ready(in_ready), .in_bit(in_bit), .in_kind(in_kind), .in_last(in_last),
        .sel_valid(sel_valid), .sel_second(sel_second), .sel_step(sel_step),
        .run_sum(run_sum), .done(done), .order_err(order_err));

    always #5 ref_clk = ~ref_clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        num_checks++;
        if (seen !== want) begin
            fails++;
            $display("CHECK FAILED at %0t: seen %08h expected %08h", $time, seen, want);
        end
    endtask

    task automatic summarize();
        if (fails == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Pulse-width level continues from the previous bit; a ONE toggles it; low level counts -1, high +1.
    task automatic acc(input logic b, inout int s, inout logic l);
        l = l ^ b;
        s = s + (l ? 1 : -1);
    endtask

    task automatic put(input logic b, input rdc_pkg::rdc_kind_t k, input logic last,
                       input logic ba, input logic bb);
        i_enc.push(b, k, last);
        acc(ba, s_a, l_a);
        acc(bb, s_b, l_b);
    endtask

    task automatic block(input logic last);
        int n;
        logic b;
        n = $urandom_range(6, 2);
        for (int i = 0; i < n; i++) begin
            b = $urandom;
            put(b, rdc_pkg::RDC_KIND_DATA, last && i == n - 1, b, b);
        end
    endtask

    task automatic prefix(input logic bad);
        logic [19:0] p;
        logic b;
        p = 20'h10102;
        for (int i = 0; i < 20; i++) begin
            b = (i == 1) ? 1'($urandom) : p[19-i] ^ (bad && i == 0);
            put(b, rdc_pkg::RDC_KIND_PREFIX, 1'h0, b, b);
        end
    endtask

    task automatic decide(input int m);
        logic sec;
        sec = (s_b < 0 ? -s_b : s_b) < (s_a < 0 ? -s_a : s_a);
        exp_sec.push_back(sec);
        exp_step.push_back(m);
        exp_sum.push_back(sec ? s_b : s_a);
        if (sec) begin
            s_a = s_b;
            l_a = l_b;
        end else begin
            s_b = s_a;
            l_b = l_a;
        end
    endtask

    task automatic sector(input logic bad, input int areas);
        logic t;
        s_a = 0;
        s_b = 0;
        l_a = 1'h0;
        l_b = 1'h0;
        repeat (4) begin
            t = $urandom;
            put(t, rdc_pkg::RDC_KIND_PREAMBLE, 1'h0, t, t);
        end
        repeat (4) begin
            t = $urandom;
            put(t, rdc_pkg::RDC_KIND_SYNC, 1'h0, t, t);
        end
        block(1'h0);
        prefix(bad);
        for (int m = 1; m <= areas; m++) begin
            for (int i = 0; i < 3; i++) begin
                t = $urandom;
                put(t, rdc_pkg::RDC_KIND_TAIL, 1'h0, 1'h0, i == 0);
            end
            t = $urandom;
            put(t, rdc_pkg::RDC_KIND_TAIL, 1'h0, t, t);
            block(m == 39);
            if (m < 39) prefix(1'h0);
            decide(m);
        end
    endtask

    always @(negedge ref_clk) begin
        if (sel_valid === 1'h1) begin
            if (exp_sec.size() == 0) begin
                check(32'(sel_valid), 32'h0);
            end else begin
                check(32'(sel_second), 32'(exp_sec.pop_front()));
                check(32'(sel_step), 32'(exp_step.pop_front()));
                check(32'(run_sum), 32'(exp_sum.pop_front()));
            end
        end
    end

    task automatic settle(input logic want_done);
        int i;
        for (i = 0; i < 20000; i++) begin
            @(negedge ref_clk);
            if (i_enc.qb.size() == 0 && (!want_done || done === 1'h1)) break;
        end
        if (i == 20000) begin
            fails++;
            summarize();
        end
        repeat (4) @(negedge ref_clk);
    endtask

    task automatic do_reset();
        @(negedge ref_clk);
        rst <= 1'h1;
        repeat (3) @(negedge ref_clk);
        rst <= 1'h0;
        exp_sec.delete();
        exp_step.delete();
        exp_sum.delete();
        @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    task automatic end_checks();
        check(32'(done), 32'h1);
        check(32'(in_ready), 32'h0);
        check(32'(order_err), 32'h0);
        check(32'(exp_sec.size()), 32'h0);
    endtask

    initial begin
        ref_clk = 1'h0;
        rst = 1'h1;
        slow = 1'h0;
        fails = 0;
        num_checks = 0;
        void'($urandom(32'hCBC44137));
        do_reset();
        sector(1'h0, 39);
        settle(1'h1);
        end_checks();
        do_reset();
        sector(1'h1, 2);
        settle(1'h0);
        check(32'(order_err), 32'h1);
        check(32'(done), 32'h0);
        do_reset();
        check(32'(order_err), 32'h0);
        check(32'(sel_step), 32'h0);
        slow = 1'h1;
        sector(1'h0, 39);
        settle(1'h1);
        end_checks();
        summarize();
    end
endmodule
